/* core/clk_gate_pkg.sv */
/*
 * constants for the divided-clock gating and wake-source register block:
 * register offsets, reset values, field positions and the unlock key.
 * assumes a 32-bit register port with 12-bit byte addresses.
 */
package clk_gate_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_MAIN_CTRL = 12'h000;
   localparam logic [11:0] OFF_CPU_SEL = 12'h004;
   localparam logic [11:0] OFF_HSB_SEL = 12'h008;
   localparam logic [11:0] OFF_PBA_SEL = 12'h00c;
   localparam logic [11:0] OFF_PBB_SEL = 12'h010;
   localparam logic [11:0] OFF_CPU_GATE = 12'h020;
   localparam logic [11:0] OFF_HSB_GATE = 12'h024;
   localparam logic [11:0] OFF_PBA_GATE = 12'h028;
   localparam logic [11:0] OFF_PBB_GATE = 12'h02c;
   localparam logic [11:0] OFF_DIV_GATE = 12'h040;
   localparam logic [11:0] OFF_CFD_CTRL = 12'h054;
   localparam logic [11:0] OFF_UNLOCK = 12'h058;
   localparam logic [11:0] OFF_IRQ_EN = 12'h0c0;
   localparam logic [11:0] OFF_IRQ_DIS = 12'h0c4;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h0c8;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h0cc;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h0d0;
   localparam logic [11:0] OFF_GEN_STAT = 12'h0d4;
   localparam logic [11:0] OFF_PERIPHERAL_POWER_CONTROL = 12'h160;
   localparam logic [11:0] OFF_RST_SRC = 12'h180;
   localparam logic [11:0] OFF_WAKE_SRC = 12'h184;
   localparam logic [11:0] OFF_ASYNC_WAKE_ENABLE = 12'h188;
   localparam logic [11:0] OFF_CONFIG = 12'h3f8;
   localparam logic [11:0] OFF_VERSION = 12'h3fc;

   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_CPU_GATE = 32'h0001_0001;
   localparam logic [31:0] RST_HSB_GATE = 32'h0000_007f;
   localparam logic [31:0] RST_PBA_GATE = 32'h0fff_ffff;
   localparam logic [31:0] RST_PBB_GATE = 32'h0000_000f;
   localparam logic [6:0] RST_DIV_GATE = 7'h7f;
   localparam logic [31:0] RST_GEN_STAT = 32'h0000_0020;
   localparam logic [31:0] RST_PERIPHERAL_POWER_CONTROL = 32'h0000_01fa;
   localparam logic [31:0] CONFIG_VAL = 32'h0000_0043;
   // arbitrary neutral version value
   localparam logic [31:0] VERSION_VAL = 32'h0000_0100;

   // unlock word: key in [31:24], protected register offset in [11:0]
   localparam logic [7:0] UNLOCK_KEY = 8'haa;
   localparam int KEY_LSB = 24;

   localparam int DIV_W = 7;
   localparam int WAKE_W = 18;
   localparam logic [17:0] WAKE_VALID = 18'h3_007f;

   // own interrupt events, bit positions in status/mask
   localparam int EV_LOCK_VIOL = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_W = 2;
endpackage

/* core/clk_gate.sv */
/*
 * divided-clock gate and wake-source register block with a simple
 * register port (read data one cycle after the read strobe) and one
 * level interrupt. assumes all inputs except wake_event_in and sleeping share sys_clk;
 * divided clocks are delivered as enables to the timer and serial units.
 */
`timescale 1ns/1ns
module clk_gate
   import clk_gate_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [WAKE_W-1:0] wake_event_in,
   input wire logic sleeping,
   input wire logic clocks_allowed,
   output logic timer_div_clock_b,
   output logic timer_div_clock_c,
   output logic timer_div_clock_d,
   output logic timer_div_clock_e,
   output logic [3:0] serial_div_clock,
   output logic [DIV_W-1:0] div_clock_en,
   output logic irq
);
   logic [31:0] main_ctrl_q, cpu_sel_q, pba_sel_q, pbb_sel_q;
   logic [31:0] cpu_gate_q, hsb_gate_q, pba_gate_q, pbb_gate_q;
   logic [31:0] cfd_ctrl_q, peripheral_power_control_q, async_wake_enable_q;
   logic [DIV_W-1:0] div_gate_q;
   logic unlock_q;
   logic [11:0] unlock_off_q;
   logic [WAKE_W-1:0] wake_src_q;
   logic [WAKE_W-1:0] wake_s1_q, wake_s2_q;
   logic sleep_s1_q, sleep_s2_q;
   logic [EV_W-1:0] irq_mask_q, irq_stat_q, ev_set;
   logic [DIV_W:0] div_cnt_q;
   logic [DIV_W-1:0] div_en_q;
   logic [DIV_W-1:0] div_pulse;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   // write lands on address only if strobe set
   logic wr_div, wr_unlock, gate_ok;
   assign wr_div = wr && hit(addr, OFF_DIV_GATE);
   assign wr_unlock = wr && hit(addr, OFF_UNLOCK);
   assign gate_ok = unlock_q && unlock_off_q == OFF_DIV_GATE;

   // the unlock is single-use: any other write in between cancels it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         unlock_q <= 1'b0;
         unlock_off_q <= 12'h000;
      end else if (wr_unlock) begin
         unlock_q <= wdata[31:KEY_LSB] == UNLOCK_KEY;
         unlock_off_q <= wdata[11:0];
      end else if (wr) begin
         unlock_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_gate_q <= RST_DIV_GATE;
      end else if (wr_div && gate_ok) begin
         div_gate_q <= wdata[DIV_W-1:0];
      end
   end

   // general read/write registers; they only store for software
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         main_ctrl_q <= RST_ZERO;
         cpu_sel_q <= RST_ZERO;
         pba_sel_q <= RST_ZERO;
         pbb_sel_q <= RST_ZERO;
         cpu_gate_q <= RST_CPU_GATE;
         hsb_gate_q <= RST_HSB_GATE;
         pba_gate_q <= RST_PBA_GATE;
         pbb_gate_q <= RST_PBB_GATE;
         cfd_ctrl_q <= RST_ZERO;
         peripheral_power_control_q <= RST_PERIPHERAL_POWER_CONTROL;
         async_wake_enable_q <= RST_ZERO;
      end else if (wr) begin
         if (hit(addr, OFF_MAIN_CTRL)) begin
            main_ctrl_q <= wdata;
         end
         if (hit(addr, OFF_CPU_SEL)) begin
            cpu_sel_q <= wdata;
         end
         if (hit(addr, OFF_PBA_SEL)) begin
            pba_sel_q <= wdata;
         end
         if (hit(addr, OFF_PBB_SEL)) begin
            pbb_sel_q <= wdata;
         end
         if (hit(addr, OFF_CPU_GATE)) begin
            cpu_gate_q <= wdata;
         end
         if (hit(addr, OFF_HSB_GATE)) begin
            hsb_gate_q <= wdata;
         end
         if (hit(addr, OFF_PBA_GATE)) begin
            pba_gate_q <= wdata;
         end
         if (hit(addr, OFF_PBB_GATE)) begin
            pbb_gate_q <= wdata;
         end
         if (hit(addr, OFF_CFD_CTRL)) begin
            cfd_ctrl_q <= wdata;
         end
         if (hit(addr, OFF_PERIPHERAL_POWER_CONTROL)) begin
            peripheral_power_control_q <= wdata;
         end
         if (hit(addr, OFF_ASYNC_WAKE_ENABLE)) begin
            async_wake_enable_q <= wdata;
         end
      end
   end

   // free-running divider; bit n toggles at sys_clk / 2^(n+1)
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   // one-cycle enable per divided period, gated by the mask and power mode
   genvar n;
   generate
      for (n = 0; n < DIV_W; n++) begin : g_div
         assign div_pulse[n] = &div_cnt_q[n:0];
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_en_q <= '0;
      end else begin
         div_en_q <= div_pulse & div_gate_q & {DIV_W{clocks_allowed}};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer_div_clock_b <= 1'b0;
         timer_div_clock_c <= 1'b0;
         timer_div_clock_d <= 1'b0;
         timer_div_clock_e <= 1'b0;
         serial_div_clock <= 4'h0;
         div_clock_en <= '0;
      end else begin
         timer_div_clock_b <= div_en_q[0];
         timer_div_clock_c <= div_en_q[2];
         timer_div_clock_d <= div_en_q[4];
         timer_div_clock_e <= div_en_q[6];
         serial_div_clock <= {4{div_en_q[2]}};
         div_clock_en <= div_en_q;
      end
   end

   // wake events and sleep state come from the always-on domain
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wake_s1_q <= '0;
         wake_s2_q <= '0;
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= wake_event_in;
         wake_s2_q <= wake_s1_q;
         sleep_s1_q <= sleeping;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   // latest wake source only: a new wake replaces the old record
   logic wake_hit;
   assign wake_hit = sleep_s2_q && |(wake_s2_q & WAKE_VALID);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wake_src_q <= '0;
      end else if (wake_hit) begin
         wake_src_q <= wake_s2_q & WAKE_VALID;
      end
   end

   assign ev_set[EV_LOCK_VIOL] = wr_div && !gate_ok;
   assign ev_set[EV_WAKE] = wake_hit;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask_q <= '0;
      end else if (wr && hit(addr, OFF_IRQ_EN)) begin
         irq_mask_q <= irq_mask_q | wdata[EV_W-1:0];
      end else if (wr && hit(addr, OFF_IRQ_DIS)) begin
         irq_mask_q <= irq_mask_q & ~wdata[EV_W-1:0];
      end
   end

   // a set arriving with a clear wins so no event is lost
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_stat_q <= '0;
      end else if (wr && hit(addr, OFF_IRQ_CLR)) begin
         irq_stat_q <= (irq_stat_q & ~wdata[EV_W-1:0]) | ev_set;
      end else begin
         irq_stat_q <= irq_stat_q | ev_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_q | ev_set) & irq_mask_q);
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr)
         OFF_MAIN_CTRL: rd_mux = main_ctrl_q;
         OFF_CPU_SEL: rd_mux = cpu_sel_q;
         OFF_HSB_SEL: rd_mux = cpu_sel_q;
         OFF_PBA_SEL: rd_mux = pba_sel_q;
         OFF_PBB_SEL: rd_mux = pbb_sel_q;
         OFF_CPU_GATE: rd_mux = cpu_gate_q;
         OFF_HSB_GATE: rd_mux = hsb_gate_q;
         OFF_PBA_GATE: rd_mux = pba_gate_q;
         OFF_PBB_GATE: rd_mux = pbb_gate_q;
         OFF_DIV_GATE: rd_mux = {25'h000_0000, div_gate_q};
         OFF_CFD_CTRL: rd_mux = cfd_ctrl_q;
         OFF_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_q};
         OFF_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_q};
         OFF_GEN_STAT: rd_mux = RST_GEN_STAT;
         OFF_PERIPHERAL_POWER_CONTROL: rd_mux = peripheral_power_control_q;
         OFF_WAKE_SRC: rd_mux = {14'h0000, wake_src_q};
         OFF_ASYNC_WAKE_ENABLE: rd_mux = async_wake_enable_q;
         OFF_CONFIG: rd_mux = CONFIG_VAL;
         OFF_VERSION: rd_mux = VERSION_VAL;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule

/* verif/clk_gate_sva.sv */
/*
 checker for the divided-clock gate block.
 assumes it is bound to clk_gate and sees only its ports.
*/
`timescale 1ns/1ns
module clk_gate_sva
   import clk_gate_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic clocks_allowed,
   input wire logic timer_div_clock_b,
   input wire logic timer_div_clock_c,
   input wire logic timer_div_clock_d,
   input wire logic timer_div_clock_e,
   input wire logic [3:0] serial_div_clock,
   input wire logic [DIV_W-1:0] div_clock_en,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_clk_b_map: assert property (timer_div_clock_b == div_clock_en[0])
      else $error("timer clock b differs from gate bit 0");
   a_clk_c_map: assert property (timer_div_clock_c == div_clock_en[2] &&
      serial_div_clock == {4{div_clock_en[2]}}) else $error("clock c or serial map wrong");
   a_clk_de_map: assert property (timer_div_clock_d == div_clock_en[4] &&
      timer_div_clock_e == div_clock_en[6]) else $error("clock d or e map wrong");
   a_div2_gap: assert property (div_clock_en[0] |=> !div_clock_en[0])
      else $error("div by 2 pulses too close");
   a_div8_gap: assert property (div_clock_en[2] |=> !div_clock_en[2] [*3])
      else $error("div by 8 pulses too close");
   a_power_off: assert property (!clocks_allowed [*3] |-> div_clock_en == '0)
      else $error("divided clock runs while power mode forbids");
   a_wake_zero: assert property (rd && addr == OFF_WAKE_SRC |=>
      rdata[15:7] == '0 && rdata[31:18] == '0) else $error("reserved wake bits set");
   a_irq_off: assert property (wr && addr == OFF_IRQ_DIS && wdata[EV_W-1:0] == '1
      |=> ##1 !irq) else $error("irq stays after disable");
endmodule
bind clk_gate clk_gate_sva chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clocks_allowed(clocks_allowed),
   .timer_div_clock_b(timer_div_clock_b), .timer_div_clock_c(timer_div_clock_c),
   .timer_div_clock_d(timer_div_clock_d), .timer_div_clock_e(timer_div_clock_e),
   .serial_div_clock(serial_div_clock), .div_clock_en(div_clock_en), .irq(irq));

/* verif/periph_model.sv */
/*
 timer and serial units seen as pulse counters on their clock enables.
 assumes enables are one-cycle pulses on sys_clk.
*/
`timescale 1ns/1ns
module periph_model (
   input wire logic sys_clk,
   input wire logic clr,
   input wire logic [4:0] clk_en,
   output logic [15:0] cnt [5]
);
   // a unit only sees ticks, so counting them is all it can judge
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 5; i++) begin
         cnt[i] <= clr ? 16'h0000 : cnt[i] + 16'(clk_en[i]);
      end
   end
endmodule

/* verif/clk_gate_tb.sv */
/*
 self-checking bench for clk_gate with peripheral pulse counters.
 assumes the checker is bound by its own file.
*/
`timescale 1ns/1ns
module clk_gate_tb;
   import clk_gate_pkg::*;
   localparam logic [31:0] KEY_W = {UNLOCK_KEY, 12'h000, OFF_DIV_GATE};
   logic sys_clk = 0, rst = 1, wr = 0, rd = 0, sleeping = 0, allowed = 1, clr = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [WAKE_W-1:0] wake = '0;
   logic ck_b, ck_c, ck_d, ck_e, irq;
   logic [3:0] ser;
   logic [DIV_W-1:0] den;
   logic [15:0] cnt [5];
   int mismatches = 0, check_count = 0;
   always #50 sys_clk = ~sys_clk;
   clk_gate dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .wake_event_in(wake), .sleeping(sleeping),
      .clocks_allowed(allowed), .timer_div_clock_b(ck_b), .timer_div_clock_c(ck_c),
      .timer_div_clock_d(ck_d), .timer_div_clock_e(ck_e), .serial_div_clock(ser),
      .div_clock_en(den), .irq(irq));
   periph_model units (.sys_clk(sys_clk), .clr(clr),
      .clk_en({ser[0], ck_e, ck_d, ck_c, ck_b}), .cnt(cnt));
   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
   endtask
   task rd_reg(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      check("rdata", rdata, exp);
   endtask
   // any window that is a whole number of periods holds an exact pulse count
   task rates(input logic [15:0] b, c, d, e, s);
      @(posedge sys_clk);
      wr <= 1'b0;
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (256) @(posedge sys_clk);
      #1;
      check("clk_b", 32'(cnt[0]), 32'(b));
      check("clk_c", 32'(cnt[1]), 32'(c));
      check("clk_d", 32'(cnt[2]), 32'(d));
      check("clk_e", 32'(cnt[3]), 32'(e));
      check("serial", 32'(cnt[4]), 32'(s));
   endtask
   task t_reset_values;
      rd_reg(OFF_DIV_GATE, 32'(RST_DIV_GATE));
      rd_reg(OFF_CPU_GATE, RST_CPU_GATE);
      rd_reg(OFF_PBA_GATE, RST_PBA_GATE);
      rd_reg(OFF_PERIPHERAL_POWER_CONTROL, RST_PERIPHERAL_POWER_CONTROL);
      rd_reg(OFF_WAKE_SRC, RST_ZERO);
      wr_reg(OFF_CONFIG, RST_ZERO);
      rd_reg(OFF_CONFIG, CONFIG_VAL);
      rd_reg(12'h014, RST_ZERO);
   endtask
   task t_power;
      @(posedge sys_clk);
      allowed <= 1'b0;
      // two pipeline stages still carry pulses launched before the power mode dropped
      repeat (2) @(posedge sys_clk);
      rates(0, 0, 0, 0, 0);
      @(posedge sys_clk);
      allowed <= 1'b1;
   endtask
   task t_lock;
      wr_reg(OFF_DIV_GATE, RST_ZERO);
      rd_reg(OFF_DIV_GATE, 32'h0000_007f);
      wr_reg(OFF_UNLOCK, KEY_W);
      wr_reg(OFF_ASYNC_WAKE_ENABLE, RST_ZERO);
      wr_reg(OFF_DIV_GATE, RST_ZERO);
      rd_reg(OFF_DIV_GATE, 32'h0000_007f);
      rd_reg(OFF_IRQ_STAT, 32'h0000_0001);
      wr_reg(OFF_UNLOCK, KEY_W);
      wr_reg(OFF_DIV_GATE, 32'h0000_0005);
      rd_reg(OFF_DIV_GATE, 32'h0000_0005);
      rates(128, 32, 0, 0, 32);
   endtask
   task t_irq;
      wr_reg(OFF_IRQ_EN, 32'h0000_0001);
      rd_reg(OFF_IRQ_MASK, 32'h0000_0001);
      check("irq", 32'(irq), 1);
      wr_reg(OFF_IRQ_DIS, 32'h0000_0003);
      rd_reg(OFF_IRQ_MASK, RST_ZERO);
      check("irq", 32'(irq), 0);
      wr_reg(OFF_IRQ_CLR, 32'h0000_0001);
      rd_reg(OFF_IRQ_STAT, RST_ZERO);
   endtask
   task t_wake;
      @(posedge sys_clk);
      sleeping <= 1'b1;
      wake <= 18'h1_ff80;
      repeat (6) @(posedge sys_clk);
      sleeping <= 1'b0;
      wake <= '0;
      rd_reg(OFF_WAKE_SRC, 32'h0001_0000);
      wr_reg(OFF_IRQ_EN, 32'h0000_0002);
      rd_reg(OFF_IRQ_STAT, 32'h0000_0002);
      check("irq", 32'(irq), 1);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_values;
      rates(128, 32, 8, 2, 32);
      t_power;
      t_lock;
      t_irq;
      t_wake;
      print_verdict;
   end
   initial begin
      #2000000;
      mismatches++;
      print_verdict;
   end
endmodule
